// *** design/async_byte_fifo_host_port.sv ***
// top: device side of the asynchronous 8-bit fifo host port
// Function
// - read strobe low drives current receive byte
// - read strobe falling edge consumes receive byte; next loads after strobe rises
// - write strobe falling edge captures bus byte
// - transmit flag high when no room; no writes
// - receive flag low when byte waiting
// - both flags undriven during reset
// - remote wakeup in suspend makes receive pin input
// - receive pin low 20ms in suspend requests resume
// - inputs pull up; option pulls low in suspend
// - send-now input flushes transmit data
// - send-now during suspend requests wakeup instead
// - active-low reset input resets whole device
// - auxiliary pin functions from configuration store
`timescale 1ns/1ps
`default_nettype none
module async_byte_fifo_host_port
  import fifo_port_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // parallel data bus pins
  input  wire logic [DATA_W-1:0] bus_data_in,
  output logic      [DATA_W-1:0] bus_data_out,
  output logic                   bus_data_oe_out,
  // strobes and send-now pins
  input  wire logic              rd_strobe_n_in,
  input  wire logic              wr_strobe_in,
  input  wire logic              send_now_wake_n_in,
  // flag pins
  output logic                   tx_space_flag_n_out,
  output logic                   tx_space_flag_oe_out,
  input  wire logic              rx_avail_flag_n_in,
  output logic                   rx_avail_flag_n_out,
  output logic                   rx_avail_flag_oe_out,
  // input pin pull control
  output logic                   pull_up_en_out,
  output logic                   pull_down_en_out,
  // auxiliary pins
  input  wire logic              aux_config_pin_a_in,
  output logic                   aux_config_pin_a_out,
  output logic                   aux_config_pin_a_oe_out,
  input  wire logic              aux_config_pin_b_in,
  output logic                   aux_config_pin_b_out,
  output logic                   aux_config_pin_b_oe_out,
  output logic                   aux_a_level_out,
  output logic                   aux_b_level_out,
  // configuration store and usb engine
  input  wire port_cfg_t         cfg_in,
  input  wire logic              suspend_indicator_n_in,
  input  wire byte_beat_t        rx_beat_in,
  output logic                   rx_ready_out,
  output byte_beat_t             tx_beat_out,
  input  wire logic              tx_ready_in,
  output logic                   flush_req_out,
  output logic                   resume_req_out
);

  // =========================================================
  // pin synchronisers
  logic rd_n_s;
  logic wr_s;
  logic wr_n_s;
  logic send_now_wake_n_n_s;
  logic rxf_pin_s;
  logic aux_a_s;
  logic aux_b_s;

  pin_sync u_sync_rd (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (rd_strobe_n_in),
    .level_out (rd_n_s)
  );
  // write strobe idles low; synced inverted so reset level matches idle
  // and no false falling edge follows reset
  pin_sync u_sync_wr (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (~wr_strobe_in),
    .level_out (wr_n_s)
  );
  assign wr_s = ~wr_n_s;
  pin_sync u_sync_send_now_wake_n (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (send_now_wake_n_in),
    .level_out (send_now_wake_n_n_s)
  );
  pin_sync u_sync_rxf (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (rx_avail_flag_n_in),
    .level_out (rxf_pin_s)
  );
  pin_sync u_sync_aux_a (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (aux_config_pin_a_in),
    .level_out (aux_a_s)
  );
  pin_sync u_sync_aux_b (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (aux_config_pin_b_in),
    .level_out (aux_b_s)
  );

  // =========================================================
  // auxiliary pin function decode, used for both pins
  function automatic pin_drive_t aux_drive(input logic [2:0] sel,
                                           input logic susp,
                                           input logic rxf_n,
                                           input logic txe_n);
    pin_drive_t d;
    d = '{out: 1'b0, oe: 1'b1};
    case (sel)
      AUX_SEL_DRIVE_0:  d.out = 1'b0;
      AUX_SEL_DRIVE_1:  d.out = 1'b1;
      AUX_SEL_SUSPEND:  d.out = susp;
      AUX_SEL_RX_AVAIL: d.out = rxf_n;
      AUX_SEL_TX_SPACE: d.out = txe_n;
      default:          d.oe  = 1'b0;
    endcase
    return d;
  endfunction

  // =========================================================
  // state
  logic                 rd_n_q;
  logic                 rd_n_d;
  logic                 wr_q;
  logic                 wr_d;
  logic                 send_now_wake_n_n_q;
  logic                 send_now_wake_n_n_d;
  logic                 rx_full_q;
  logic                 rx_full_d;
  logic [DATA_W-1:0]    rx_byte_q;
  logic [DATA_W-1:0]    rx_byte_d;
  byte_beat_t           tx_q;
  byte_beat_t           tx_d;
  logic                 flush_q;
  logic                 flush_d;
  logic                 resume_q;
  logic                 resume_d;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;
  logic [WAKE_CNT_W-1:0] wake_cnt_d;
  logic                 in_reset_q;
  logic                 suspended;
  logic                 rxf_as_input;
  logic                 rd_fall;
  logic                 wr_fall;
  logic                 send_now_wake_n_fall;

  assign suspended    = suspend_indicator_n_in;
  assign rxf_as_input = cfg_in.wake_en & suspended;
  assign rd_fall      = rd_n_q & ~rd_n_s;
  assign wr_fall      = wr_q & ~wr_s;
  assign send_now_wake_n_fall    = send_now_wake_n_n_q & ~send_now_wake_n_n_s;

  always_comb begin
    rd_n_d     = rd_n_s;
    wr_d       = wr_s;
    send_now_wake_n_n_d   = send_now_wake_n_n_s;
    rx_full_d  = rx_full_q;
    rx_byte_d  = rx_byte_q;
    tx_d       = tx_q;
    flush_d    = 1'b0;
    resume_d   = 1'b0;
    wake_cnt_d = '0;
    // falling read edge consumes held byte; flag rises until refill
    if (rd_fall && rx_full_q) begin
      rx_full_d = 1'b0;
    end
    // refill only while strobe is high so the byte on the bus holds
    if (!rx_full_d && rx_beat_in.valid && rd_n_s) begin
      rx_full_d = 1'b1;
      rx_byte_d = rx_beat_in.data;
    end
    if (tx_q.valid && tx_ready_in) begin
      tx_d.valid = 1'b0;
    end
    // pin byte is sampled late; host holds data past the edge
    if (wr_fall && !tx_q.valid) begin
      tx_d = '{valid: 1'b1, data: bus_data_in};
    end
    if (send_now_wake_n_fall) begin
      if (suspended) begin
        resume_d = 1'b1;
      end else begin
        flush_d = 1'b1;
      end
    end
    if (rxf_as_input && !rxf_pin_s) begin
      if (wake_cnt_q == WAKE_CNT_W'(WAKE_MIN_CYC)) begin
        wake_cnt_d = wake_cnt_q;
      end else begin
        wake_cnt_d = wake_cnt_q + 1'b1;
      end
      if (wake_cnt_q == WAKE_CNT_W'(WAKE_MIN_CYC - 1)) begin
        resume_d = 1'b1;
      end
    end
  end

  // whole port returns to idle from the reset pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_n_q     <= 1'b1;
      wr_q       <= 1'b0;
      send_now_wake_n_n_q   <= 1'b1;
      rx_full_q  <= 1'b0;
      rx_byte_q  <= 8'h00;
      tx_q       <= '0;
      flush_q    <= 1'b0;
      resume_q   <= 1'b0;
      wake_cnt_q <= '0;
      in_reset_q <= 1'b1;
    end else begin
      rd_n_q     <= rd_n_d;
      wr_q       <= wr_d;
      send_now_wake_n_n_q   <= send_now_wake_n_n_d;
      rx_full_q  <= rx_full_d;
      rx_byte_q  <= rx_byte_d;
      tx_q       <= tx_d;
      flush_q    <= flush_d;
      resume_q   <= resume_d;
      wake_cnt_q <= wake_cnt_d;
      in_reset_q <= 1'b0;
    end
  end

  // =========================================================
  // pin drive
  pin_drive_t aux_a_drv;
  pin_drive_t aux_b_drv;

  always_comb begin
    aux_a_drv = aux_drive(cfg_in.aux_a_sel, suspended,
                          ~rx_full_q, tx_q.valid);
    aux_b_drv = aux_drive(cfg_in.aux_b_sel, suspended,
                          ~rx_full_q, tx_q.valid);
  end

  assign bus_data_out         = rx_byte_q;
  // bus driven only for a low synchronised read strobe
  assign bus_data_oe_out      = ~in_reset_q & ~rd_n_s;
  assign tx_space_flag_n_out  = tx_q.valid;
  assign tx_space_flag_oe_out = ~in_reset_q;
  assign rx_avail_flag_n_out  = ~rx_full_q;
  assign rx_avail_flag_oe_out = ~in_reset_q & ~rxf_as_input;
  assign pull_down_en_out     = cfg_in.pull_low_en & suspended;
  assign pull_up_en_out       = ~pull_down_en_out;
  assign aux_config_pin_a_out    = aux_a_drv.out;
  assign aux_config_pin_a_oe_out = aux_a_drv.oe & ~in_reset_q;
  assign aux_config_pin_b_out    = aux_b_drv.out;
  assign aux_config_pin_b_oe_out = aux_b_drv.oe & ~in_reset_q;
  assign aux_a_level_out      = aux_a_s;
  assign aux_b_level_out      = aux_b_s;
  assign rx_ready_out         = ~rx_full_q & rd_n_s;
  assign tx_beat_out          = tx_q;
  assign flush_req_out        = flush_q;
  assign resume_req_out       = resume_q;

endmodule // async_byte_fifo_host_port
`default_nettype wire

// *** design/fifo_port_pkg.sv ***
// package: constants and carrier types for the parallel fifo host port
package fifo_port_pkg;

  // =========================================================
  // data and timing
  localparam int DATA_W        = 8;
  localparam int CLK_FREQ_HZ   = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_MIN_MS   = 20;
  // least time in whole cycles; per-ms cycle count rounds down
  localparam int WAKE_MIN_CYC  =
    (WAKE_MIN_MS * (CLK_FREQ_HZ / 1000) + 0) ;
  localparam int WAKE_CNT_W    = 21;
  localparam int SYNC_STAGES   = 3;

  // =========================================================
  // auxiliary pin function select codes
  localparam logic [2:0] AUX_SEL_DRIVE_0    = 3'h0;
  localparam logic [2:0] AUX_SEL_DRIVE_1    = 3'h1;
  localparam logic [2:0] AUX_SEL_SUSPEND    = 3'h2;
  localparam logic [2:0] AUX_SEL_RX_AVAIL   = 3'h3;
  localparam logic [2:0] AUX_SEL_TX_SPACE   = 3'h4;
  localparam logic [2:0] AUX_SEL_INPUT      = 3'h5;

  // =========================================================
  // configuration store field layout
  localparam int CFG_WAKE_EN_BIT   = 0;
  localparam int CFG_PULL_LOW_BIT  = 1;
  localparam int CFG_AUX_A_LSB     = 2;
  localparam int CFG_AUX_B_LSB     = 5;
  localparam int CFG_W             = 8;

  // =========================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } byte_beat_t;

  typedef struct packed {
    logic wake_en;
    logic pull_low_en;
    logic [2:0] aux_a_sel;
    logic [2:0] aux_b_sel;
  } port_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage : fifo_port_pkg

// *** design/pin_sync.sv ***
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import fifo_port_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // pin side
  input  wire logic pin_in,
  // filtered level
  output logic      level_out
);

  // =========================================================
  // stages
  logic [SYNC_STAGES-1:0] stage_q;
  logic [SYNC_STAGES-1:0] stage_d;
  logic                   level_q;
  logic                   level_d;

  always_comb begin
    stage_d = {stage_q[SYNC_STAGES-2:0], pin_in};
    level_d = level_q;
    // first stage is read only by the second
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  // pins idle high, so reset to high
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage_q <= '1;
      level_q <= 1'b1;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule // pin_sync
`default_nettype wire

// *** test/async_byte_fifo_host_port_tb.sv ***
// testbench: random and corner traffic through the fifo host port
`timescale 1ns/1ps
`default_nettype none
module async_byte_fifo_host_port_tb;
  import fifo_port_pkg::*;
  // ====================
  // signals
  logic clk_in = 1'b0, rst_n_in = 1'b0, susp = 1'b0, send_n = 1'b1, hold_tx = 1'b0;
  logic aux_a_in = 1'b0, aux_b_in = 1'b0, tx_ready_in = 1'b0, rd_n, wr;
  port_cfg_t  cfg_in = '0;
  byte_beat_t rx_beat_in = '0, tx_beat_out;
  logic [7:0] bus_in, bus_data_out, rxq[$], exp_rx[$], exp_tx[$], got_tx[$];
  logic bus_data_oe_out, tx_space_flag_n_out, tx_space_flag_oe_out, rx_avail_flag_n_out;
  logic rx_avail_flag_oe_out, pull_up_en_out, pull_down_en_out, rx_ready_out;
  logic aux_a_out, aux_a_oe, aux_b_out, aux_b_oe, aux_b_lvl, flush_req_out, resume_req_out;
  int   fails = 0, check_count = 0, n_flush = 0, n_res = 0;
  // flag pin has a pull-up when released
  wire logic rx_pin = rx_avail_flag_oe_out ? rx_avail_flag_n_out : 1'b1;
  always #12.5 clk_in = ~clk_in;
  async_byte_fifo_host_port i_dut (.clk_in, .rst_n_in, .bus_data_in(bus_in), .bus_data_out,
    .bus_data_oe_out, .rd_strobe_n_in(rd_n), .wr_strobe_in(wr), .send_now_wake_n_in(send_n),
    .tx_space_flag_n_out, .tx_space_flag_oe_out, .rx_avail_flag_n_in(rx_pin),
    .rx_avail_flag_n_out, .rx_avail_flag_oe_out, .pull_up_en_out, .pull_down_en_out,
    .aux_config_pin_a_in(aux_a_in), .aux_config_pin_a_out(aux_a_out),
    .aux_config_pin_a_oe_out(aux_a_oe), .aux_config_pin_b_in(aux_b_in),
    .aux_config_pin_b_out(aux_b_out), .aux_config_pin_b_oe_out(aux_b_oe),
    .aux_a_level_out(), .aux_b_level_out(aux_b_lvl), .cfg_in,
    .suspend_indicator_n_in(susp), .rx_beat_in, .rx_ready_out, .tx_beat_out, .tx_ready_in,
    .flush_req_out, .resume_req_out);
  fifo_host_model i_host (.clk_in, .dev_data_in(bus_data_out), .dev_oe_in(bus_data_oe_out),
    .tx_flag_n_in(tx_space_flag_n_out), .rx_flag_n_in(rx_pin), .bus_out(bus_in),
    .rd_n_out(rd_n), .wr_out(wr));
  // ====================
  // usb engine stand-in, stalls at random
  always @(negedge clk_in) begin
    rx_beat_in <= rxq.size() > 0 ? {1'b1, rxq[0]} : '0;
    tx_ready_in <= !hold_tx && ($urandom_range(0, 3) != 0);
  end
  always @(posedge clk_in) begin
    if (rx_ready_out && rx_beat_in.valid) void'(rxq.pop_front());
    if (tx_beat_out.valid && tx_ready_in) got_tx.push_back(tx_beat_out.data);
    n_flush += int'(flush_req_out);
    n_res += int'(resume_req_out);
  end
  // ====================
  // compare and report
  function automatic logic aux_oe_exp(input logic [2:0] sel);
    return sel != AUX_SEL_INPUT;
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %0b got %0b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic results();
    fails += i_host.tmo;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    results();
  end
  // ====================
  // scenarios
  initial begin
    logic [7:0] d;
    int nf, nr;
    void'($urandom(57520));
    repeat (6) @(negedge clk_in);
    chk_bit("tx_oe_rst", 1'b0, tx_space_flag_oe_out);
    chk_bit("rx_oe_rst", 1'b0, rx_avail_flag_oe_out);
    rst_n_in = 1'b1;
    repeat (6) @(negedge clk_in);
    // all-zero and all-one bytes first
    for (int i = 0; i < 8; i++) rxq.push_back(i < 2 ? {8{i[0]}} : 8'($urandom));
    exp_rx = rxq;
    repeat (8) @(negedge clk_in);
    chk_bit("rx_wait", 1'b0, rx_avail_flag_n_out);
    for (int i = 0; i < 8; i++) begin
      i_host.rd_byte(d);
      chk_byte("rd", exp_rx[i], d);
    end
    repeat (12) @(negedge clk_in);
    chk_bit("rx_empty", 1'b1, rx_avail_flag_n_out);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      exp_tx.push_back(d);
      i_host.wr_byte(d, 1'b0);
    end
    hold_tx = 1'b1;
    i_host.wr_byte(8'hA5, 1'b0);
    exp_tx.push_back(8'hA5);
    chk_bit("tx_full", 1'b1, tx_space_flag_n_out);
    i_host.wr_byte(8'h5A, 1'b1);
    hold_tx = 1'b0;
    repeat (20) @(negedge clk_in);
    chk_bit("tx_free", 1'b0, tx_space_flag_n_out);
    chk_byte("wr_count", 8'(exp_tx.size()), 8'(got_tx.size()));
    foreach (exp_tx[i]) chk_byte("wr", exp_tx[i], got_tx[i]);
    for (int s = 0; s < 2; s++) begin
      susp = s[0];
      nf = n_flush;
      nr = n_res;
      send_n = 1'b0;
      repeat (8) @(negedge clk_in);
      send_n = 1'b1;
      repeat (8) @(negedge clk_in);
      chk_byte("flush", 8'(nf + 1 - s), 8'(n_flush));
      chk_byte("resume", 8'(nr + s), 8'(n_res));
    end
    cfg_in.wake_en = 1'b1;
    cfg_in.pull_low_en = 1'b1;
    repeat (4) @(negedge clk_in);
    chk_bit("rx_oe_wake", 1'b0, rx_avail_flag_oe_out);
    chk_bit("pull_dn", 1'b1, pull_down_en_out);
    susp = 1'b0;
    repeat (4) @(negedge clk_in);
    chk_bit("pull_up", 1'b1, pull_up_en_out);
    chk_bit("rx_oe", 1'b1, rx_avail_flag_oe_out);
    for (int k = 0; k < 6; k++) begin
      cfg_in.aux_a_sel = 3'(k);
      cfg_in.aux_b_sel = 3'(5 - k);
      aux_b_in = k[0];
      repeat (6) @(negedge clk_in);
      chk_bit("aux_a_oe", aux_oe_exp(cfg_in.aux_a_sel), aux_a_oe);
      chk_bit("aux_b_oe", aux_oe_exp(cfg_in.aux_b_sel), aux_b_oe);
      if (k < 2) chk_bit("aux_a", k[0], aux_a_out);
      if (k > 3) chk_bit("aux_b", ~k[0], aux_b_out);
      chk_bit("aux_b_lvl", k[0], aux_b_lvl);
    end
    results();
  end
endmodule // async_byte_fifo_host_port_tb
`default_nettype wire

// *** test/fifo_host_model.sv ***
// partner: external controller driving the fifo strobes
`timescale 1ns/1ps
`default_nettype none
module fifo_host_model
  import fifo_port_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // device pins
  input  wire logic [DATA_W-1:0] dev_data_in,
  input  wire logic              dev_oe_in,
  input  wire logic              tx_flag_n_in,
  input  wire logic              rx_flag_n_in,
  // driven pins
  output logic      [DATA_W-1:0] bus_out,
  output logic                   rd_n_out = 1'b1,
  output logic                   wr_out = 1'b0
);
  // ====================
  // bus and strobes
  logic [DATA_W-1:0] wdata = 8'h00;
  logic              drv   = 1'b0;
  int                tmo   = 0;
  // released bus flips so a stale byte never passes for a match
  assign bus_out = dev_oe_in ? dev_data_in : (drv ? wdata : ~wdata);
  task automatic wr_byte(input logic [DATA_W-1:0] d, input bit blind);
    int n = 0;
    while (!blind && tx_flag_n_in !== 1'b0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 400) tmo++;
    wdata = d;
    drv = 1'b1;
    wr_out = 1'b1;
    repeat (5) @(negedge clk_in);
    wr_out = 1'b0;
    repeat (5) @(negedge clk_in);
    drv = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  task automatic rd_byte(output logic [DATA_W-1:0] d);
    int n = 0;
    while (rx_flag_n_in !== 1'b0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 400) tmo++;
    rd_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    d = bus_out;
    rd_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
endmodule // fifo_host_model
`default_nettype wire

// *** test/fifo_port_chk.sv ***
// checker: pin-level assertions for the fifo host port
`timescale 1ns/1ps
`default_nettype none
module fifo_port_chk
  import fifo_port_pkg::*;
(
  // clock and reset
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  // strobe, bus and flags
  input wire logic              rd_strobe_n_in,
  input wire logic [DATA_W-1:0] bus_data_out,
  input wire logic              bus_data_oe_out,
  input wire logic              tx_space_flag_n_out,
  input wire logic              tx_space_flag_oe_out,
  input wire logic              rx_avail_flag_n_out,
  input wire logic              rx_avail_flag_oe_out,
  // pulls, aux, config
  input wire logic              pull_up_en_out,
  input wire logic              pull_down_en_out,
  input wire logic              aux_config_pin_a_out,
  input wire logic              aux_config_pin_a_oe_out,
  input wire port_cfg_t         cfg_in,
  input wire logic              suspend_indicator_n_in,
  // engine side
  input wire byte_beat_t        tx_beat_out,
  input wire logic              tx_ready_in,
  input wire logic              flush_req_out,
  input wire logic              resume_req_out
);
  // ====================
  // properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // reset itself is the cause here, so it cannot disable the check
  property p_rst_oe;
    disable iff (1'b0) !rst_n_in |=> !tx_space_flag_oe_out && !rx_avail_flag_oe_out;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("flag driven in reset");
  property p_bus_off; rd_strobe_n_in [*5] |-> !bus_data_oe_out; endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus driven");
  property p_bus_on; !rd_strobe_n_in [*5] |-> bus_data_oe_out; endproperty
  a_bus_on: assert property (p_bus_on) else $error("bus not driven");
  property p_data_hold;
    bus_data_oe_out && $past(bus_data_oe_out) |-> $stable(bus_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("byte moved");
  property p_rx_fall; $rose(bus_data_oe_out) |-> ##[0:2] rx_avail_flag_n_out; endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx flag kept");
  property p_tx_full; $rose(tx_beat_out.valid) |-> ##[0:1] tx_space_flag_n_out; endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx flag low");
  property p_tx_hold;
    tx_beat_out.valid && !tx_ready_in |=> tx_beat_out.valid && $stable(tx_beat_out.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost");
  property p_wake_in;
    (cfg_in.wake_en && suspend_indicator_n_in) [*2] |-> !rx_avail_flag_oe_out;
  endproperty
  a_wake_in: assert property (p_wake_in) else $error("rx pin driven");
  property p_pull;
    (cfg_in.pull_low_en && suspend_indicator_n_in) [*2] |-> pull_down_en_out && !pull_up_en_out;
  endproperty
  a_pull: assert property (p_pull) else $error("pull wrong");
  property p_pulse; flush_req_out || resume_req_out |=> !flush_req_out && !resume_req_out; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse long");
  property p_aux;
    (cfg_in.aux_a_sel == AUX_SEL_DRIVE_1) [*2] |-> aux_config_pin_a_oe_out && aux_config_pin_a_out;
  endproperty
  a_aux: assert property (p_aux) else $error("aux pin wrong");
  c_flush: cover property (flush_req_out);
  c_resume: cover property (resume_req_out);
  c_tx: cover property (tx_beat_out.valid && tx_ready_in);
endmodule // fifo_port_chk

bind async_byte_fifo_host_port fifo_port_chk i_chk (.clk_in, .rst_n_in, .rd_strobe_n_in,
  .bus_data_out, .bus_data_oe_out, .tx_space_flag_n_out, .tx_space_flag_oe_out,
  .rx_avail_flag_n_out, .rx_avail_flag_oe_out, .pull_up_en_out, .pull_down_en_out,
  .aux_config_pin_a_out, .aux_config_pin_a_oe_out, .cfg_in, .suspend_indicator_n_in,
  .tx_beat_out, .tx_ready_in, .flush_req_out, .resume_req_out);
`default_nettype wire
